// [rcfg_pkg.sv]
`default_nettype none
package rcfg_pkg;
  // Clock and timing
  localparam int          CLK_HZ          = 50_000_000;
  localparam int          NV_WRITE_MS     = 16;
  localparam int          NV_WRITE_CYCLES = CLK_HZ / 1000 * NV_WRITE_MS;
  localparam int          CNT_W           = 24;
  // Command framing bytes
  localparam logic [7:0]  HDR_BYTE        = 8'hff;
  localparam logic [7:0]  ESC_BYTE        = 8'hfe;
  localparam logic [7:0]  SIZE_SHORT      = 8'h02;
  localparam logic [7:0]  SIZE_LONG       = 8'h03;
  localparam logic [7:0]  ACK_BYTE        = 8'h06;
  localparam logic [7:0]  NACK_BYTE       = 8'h15;
  localparam logic [7:0]  HIGH_BIT        = 8'h80;
  // Register offsets
  localparam logic [7:0]  HOP_NV_ADDR     = 8'h00;
  localparam logic [7:0]  PWR_NV_ADDR     = 8'h02;
  localparam logic [7:0]  RATE_NV_ADDR    = 8'h03;
  localparam logic [7:0]  HOP_LIVE_ADDR   = 8'h4b;
  localparam logic [7:0]  PWR_LIVE_ADDR   = 8'h4d;
  localparam logic [7:0]  RATE_LIVE_ADDR  = 8'h4e;
  // Factory defaults and legal maxima
  localparam logic [7:0]  HOP_DEFAULT     = 8'h00;
  localparam logic [7:0]  PWR_DEFAULT     = 8'h03;
  localparam logic [7:0]  RATE_DEFAULT    = 8'h01;
  localparam logic [7:0]  HOP_MAX         = 8'h05;
  localparam logic [7:0]  PWR_MAX         = 8'h03;
  localparam logic [7:0]  RATE_MAX        = 8'h07;
  // Hop table shape
  localparam int          HOP_SEQS        = 6;
  localparam int          HOP_LEN         = 26;
  localparam int          CHAN_W          = 5;
  // Baud rates per rate code
  localparam int          BAUD_0          = 2_400;
  localparam int          BAUD_1          = 9_600;
  localparam int          BAUD_2          = 19_200;
  localparam int          BAUD_3          = 38_400;
  localparam int          BAUD_4          = 57_600;
  localparam int          BAUD_5          = 115_200;
  localparam int          BAUD_6          = 10_400;
  localparam int          BAUD_7          = 31_250;
endpackage
`default_nettype wire

// [rcfg_hop_rom.sv]
`timescale 1ns/100ps
`default_nettype none
module rcfg_hop_rom
  import rcfg_pkg::*;
(
  input  wire logic              sys_clk,   // System clock
  input  wire logic              ce,        // Clock enable
  input  wire logic [2:0]        seq_sel,   // Hop sequence 0..5
  input  wire logic [4:0]        hop_index, // Position in sequence 0..25
  output logic      [CHAN_W-1:0] channel    // Registered channel number
);
  import rcfg_pkg::*;

  logic [CHAN_W*HOP_SEQS-1:0] row;
  logic [CHAN_W-1:0]          chan_next;
  logic [CHAN_W-1:0]          chan_reg;

  ////////////////////////////////////////////////////////////////////////
  // One row per position, sequence 0 in the top field
  always_comb
  begin
    case (hop_index)
      5'h00: row = {5'h10, 5'h0f, 5'h03, 5'h1c, 5'h16, 5'h09};
      5'h01: row = {5'h01, 5'h1e, 5'h14, 5'h0b, 5'h07, 5'h18};
      5'h02: row = {5'h02, 5'h1d, 5'h15, 5'h0a, 5'h08, 5'h17};
      5'h03: row = {5'h05, 5'h1a, 5'h18, 5'h07, 5'h0b, 5'h14};
      5'h04: row = {5'h0a, 5'h15, 5'h1d, 5'h02, 5'h10, 5'h0f};
      5'h05: row = {5'h15, 5'h0a, 5'h08, 5'h17, 5'h1b, 5'h04};
      5'h06: row = {5'h0b, 5'h14, 5'h1e, 5'h01, 5'h11, 5'h0e};
      5'h07: row = {5'h17, 5'h08, 5'h0a, 5'h15, 5'h1d, 5'h02};
      5'h08: row = {5'h0e, 5'h11, 5'h01, 5'h1e, 5'h14, 5'h0b};
      5'h09: row = {5'h1d, 5'h02, 5'h10, 5'h0f, 5'h03, 5'h1c};
      5'h0a: row = {5'h1b, 5'h04, 5'h0e, 5'h11, 5'h01, 5'h1e};
      5'h0b: row = {5'h16, 5'h09, 5'h09, 5'h16, 5'h1c, 5'h03};
      5'h0c: row = {5'h0c, 5'h13, 5'h1f, 5'h00, 5'h12, 5'h0d};
      5'h0d: row = {5'h18, 5'h07, 5'h0b, 5'h14, 5'h1e, 5'h01};
      5'h0e: row = {5'h11, 5'h0e, 5'h04, 5'h1b, 5'h17, 5'h08};
      5'h0f: row = {5'h03, 5'h1c, 5'h16, 5'h09, 5'h09, 5'h16};
      5'h10: row = {5'h07, 5'h18, 5'h1a, 5'h05, 5'h0d, 5'h12};
      5'h11: row = {5'h0f, 5'h10, 5'h02, 5'h1d, 5'h15, 5'h0a};
      5'h12: row = {5'h1f, 5'h00, 5'h12, 5'h0d, 5'h05, 5'h1a};
      5'h13: row = {5'h1e, 5'h01, 5'h11, 5'h0e, 5'h04, 5'h1b};
      5'h14: row = {5'h1c, 5'h03, 5'h0f, 5'h10, 5'h02, 5'h1d};
      5'h15: row = {5'h19, 5'h06, 5'h0c, 5'h13, 5'h1f, 5'h00};
      5'h16: row = {5'h13, 5'h0c, 5'h06, 5'h19, 5'h19, 5'h06};
      5'h17: row = {5'h06, 5'h19, 5'h19, 5'h06, 5'h0c, 5'h13};
      5'h18: row = {5'h0d, 5'h12, 5'h00, 5'h1f, 5'h13, 5'h0c};
      5'h19: row = {5'h1a, 5'h05, 5'h0d, 5'h12, 5'h00, 5'h1f};
      default: row = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Field select; out of range sequences read channel 0
  always_comb
  begin
    chan_next = '0;
    if (seq_sel <= 3'h5)
      chan_next = row[(3'h5 - seq_sel) * CHAN_W +: CHAN_W];
  end

  // Read data register, frozen while ce is low
  always_ff @(posedge sys_clk)
  begin
    if (ce)
      chan_reg <= chan_next;
  end

  assign channel = chan_reg;
endmodule
`default_nettype wire

// [rcfg_regs.sv]
`timescale 1ns/100ps
`default_nettype none
module rcfg_regs
  import rcfg_pkg::*;
#(
  parameter int NV_CYCLES = NV_WRITE_CYCLES  // Stored-copy write time
)
(
  input  wire logic              sys_clk,             // System clock
  input  wire logic              rst_n,               // Reset, reloads live copies
  input  wire logic              por_n,               // Power-on reset, factory defaults
  input  wire logic              ce,                  // Clock enable
  input  wire logic              rx_valid,            // Command byte valid
  input  wire logic [7:0]        rx_data,             // Command byte
  output logic                   rx_ready,            // Command byte accepted
  output logic                   tx_valid,            // Reply byte valid
  output logic      [7:0]        tx_data,             // Reply byte
  input  wire logic              tx_ready,            // Reply byte taken
  input  wire logic [4:0]        hop_index,           // Hop position 0..25
  output logic      [CHAN_W-1:0] hop_channel,         // Channel at that position
  output logic      [7:0]        hop_sequence_select, // Live hop sequence
  output logic      [7:0]        tx_power_level,      // Live power code
  output logic      [7:0]        serial_rate_select,  // Rate code in use
  output logic      [15:0]       baud_divisor,        // Clocks per bit
  output logic                   nv_busy              // Stored-copy write running
);
  import rcfg_pkg::*;

  typedef enum logic [2:0] {ST_LOAD, ST_HDR, ST_SIZE, ST_B1, ST_B2, ST_B3, ST_NVWAIT, ST_REPLY} rcfg_state_e;

  rcfg_state_e      state_reg, state_next;
  logic [7:0]       size_reg, size_next, addr_reg, addr_next, rval_reg, rval_next;
  logic             read_reg, read_next, pend_reg, pend_next;
  logic [1:0]       len_reg, len_next, idx_reg, idx_next;
  logic [7:0]       txd_reg, txd_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [7:0]       hop_nv_reg, hop_nv_next, pwr_nv_reg, pwr_nv_next, rate_nv_reg, rate_nv_next;
  logic [7:0]       hop_reg, hop_next, pwr_reg, pwr_next, rate_reg, rate_next, eff_reg, eff_next;
  logic             cmd_done, cmd_read, cmd_ok, last_tx;
  logic [7:0]       cmd_addr, cmd_val;

  ////////////////////////////////////////////////////////////////////////
  // Address and value checks
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == HOP_NV_ADDR) || (a == PWR_NV_ADDR) || (a == RATE_NV_ADDR) ||
                 (a == HOP_LIVE_ADDR) || (a == PWR_LIVE_ADDR) || (a == RATE_LIVE_ADDR);
  endfunction

  function automatic logic value_ok(input logic [7:0] a, input logic [7:0] v);
    case (a)
      HOP_NV_ADDR, HOP_LIVE_ADDR:   value_ok = (v <= HOP_MAX);
      PWR_NV_ADDR, PWR_LIVE_ADDR:   value_ok = (v <= PWR_MAX);
      RATE_NV_ADDR, RATE_LIVE_ADDR: value_ok = (v <= RATE_MAX);
      default:                      value_ok = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] rate_div(input logic [7:0] code);
    case (code[2:0])
      3'h0:    rate_div = 16'(CLK_HZ / BAUD_0);
      3'h1:    rate_div = 16'(CLK_HZ / BAUD_1);
      3'h2:    rate_div = 16'(CLK_HZ / BAUD_2);
      3'h3:    rate_div = 16'(CLK_HZ / BAUD_3);
      3'h4:    rate_div = 16'(CLK_HZ / BAUD_4);
      3'h5:    rate_div = 16'(CLK_HZ / BAUD_5);
      3'h6:    rate_div = 16'(CLK_HZ / BAUD_6);
      default: rate_div = 16'(CLK_HZ / BAUD_7);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Command completion decode
  always_comb
  begin
    cmd_done = 1'b0;
    cmd_read = read_reg;
    cmd_addr = addr_reg;
    cmd_val  = rx_data;
    if (rx_valid && state_reg == ST_B2 && (read_reg || size_reg == SIZE_SHORT))
    begin
      cmd_done = 1'b1;
      if (read_reg)
        cmd_addr = rx_data;
    end
    else if (rx_valid && state_reg == ST_B3)
    begin
      cmd_done = 1'b1;
      cmd_val  = rx_data | HIGH_BIT;  // Long form always carries a high value
    end
    cmd_ok = addr_known(cmd_addr) && (cmd_read || value_ok(cmd_addr, cmd_val));
  end

  assign rx_ready = (state_reg != ST_LOAD) && (state_reg != ST_NVWAIT) && (state_reg != ST_REPLY);
  assign tx_valid = (state_reg == ST_REPLY);
  assign last_tx  = tx_valid && tx_ready && (idx_reg == len_reg);

  ////////////////////////////////////////////////////////////////////////
  // Parser, register updates and reply sequencing
  always_comb
  begin
    state_next   = state_reg;
    size_next    = size_reg;
    addr_next    = addr_reg;
    rval_next    = rval_reg;
    read_next    = read_reg;
    pend_next    = pend_reg;
    len_next     = len_reg;
    idx_next     = idx_reg;
    txd_next     = txd_reg;
    cnt_next     = cnt_reg;
    hop_nv_next  = hop_nv_reg;
    pwr_nv_next  = pwr_nv_reg;
    rate_nv_next = rate_nv_reg;
    hop_next     = hop_reg;
    pwr_next     = pwr_reg;
    rate_next    = rate_reg;
    eff_next     = eff_reg;
    case (state_reg)
      ST_LOAD:
      begin
        hop_next   = hop_nv_reg;
        pwr_next   = pwr_nv_reg;
        rate_next  = rate_nv_reg;
        eff_next   = rate_nv_reg;
        state_next = ST_HDR;
      end
      ST_HDR:
        if (rx_valid && rx_data == HDR_BYTE)
          state_next = ST_SIZE;
      ST_SIZE:
        if (rx_valid)
        begin
          size_next  = rx_data;
          state_next = (rx_data == SIZE_SHORT || rx_data == SIZE_LONG) ? ST_B1 : ST_HDR;
        end
      ST_B1:
        if (rx_valid)
        begin
          read_next  = (size_reg == SIZE_SHORT) && (rx_data == ESC_BYTE);
          addr_next  = rx_data;
          state_next = ST_B2;
        end
      ST_B2:
        if (rx_valid && !cmd_done)
          state_next = (rx_data == ESC_BYTE) ? ST_B3 : ST_HDR;
      ST_B3:
        state_next = state_reg;
      ST_NVWAIT:
        if (cnt_reg == '0)
          state_next = ST_REPLY;
        else
          cnt_next = cnt_reg - 1'b1;
      ST_REPLY:
        if (tx_valid && tx_ready)
        begin
          idx_next = idx_reg + 1'b1;
          txd_next = (idx_reg == 2'h0) ? addr_reg : rval_reg;
          if (last_tx)
          begin
            state_next = ST_HDR;
            if (pend_reg)
              eff_next = rate_reg;
            pend_next = 1'b0;
          end
        end
      default:
        state_next = ST_HDR;
    endcase
    // Finished command: execute and queue the reply
    if (cmd_done)
    begin
      addr_next  = cmd_addr;
      idx_next   = 2'h0;
      len_next   = 2'h0;
      txd_next   = cmd_ok ? ACK_BYTE : NACK_BYTE;
      state_next = ST_REPLY;
      if (cmd_read && cmd_ok)
      begin
        len_next = 2'h2;
        case (cmd_addr)
          HOP_NV_ADDR:    rval_next = hop_nv_reg;
          PWR_NV_ADDR:    rval_next = pwr_nv_reg;
          RATE_NV_ADDR:   rval_next = rate_nv_reg;
          HOP_LIVE_ADDR:  rval_next = hop_reg;
          PWR_LIVE_ADDR:  rval_next = pwr_reg;
          default:        rval_next = rate_reg;
        endcase
      end
      else if (!cmd_read && cmd_ok)
      begin
        case (cmd_addr)
          HOP_LIVE_ADDR:  hop_next = cmd_val;
          PWR_LIVE_ADDR:  pwr_next = cmd_val;
          RATE_LIVE_ADDR:
          begin
            rate_next = cmd_val;
            pend_next = 1'b1;
          end
          HOP_NV_ADDR:    hop_nv_next  = cmd_val;
          PWR_NV_ADDR:    pwr_nv_next  = cmd_val;
          default:        rate_nv_next = cmd_val;
        endcase
        if (cmd_addr < HOP_LIVE_ADDR)
        begin
          cnt_next   = CNT_W'(NV_CYCLES - 1);
          state_next = ST_NVWAIT;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stored copies survive rst_n, cleared to factory defaults by por_n
  always_ff @(posedge sys_clk or negedge por_n)
  begin
    if (!por_n)
    begin
      hop_nv_reg  <= HOP_DEFAULT;
      pwr_nv_reg  <= PWR_DEFAULT;
      rate_nv_reg <= RATE_DEFAULT;
    end
    else if (ce)
    begin
      hop_nv_reg  <= hop_nv_next;
      pwr_nv_reg  <= pwr_nv_next;
      rate_nv_reg <= rate_nv_next;
    end
  end

  // Live state; the load state copies the stored values in after reset
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_LOAD;
      size_reg  <= '0;
      addr_reg  <= '0;
      rval_reg  <= '0;
      read_reg  <= 1'b0;
      pend_reg  <= 1'b0;
      len_reg   <= '0;
      idx_reg   <= '0;
      txd_reg   <= '0;
      cnt_reg   <= '0;
      hop_reg   <= HOP_DEFAULT;
      pwr_reg   <= PWR_DEFAULT;
      rate_reg  <= RATE_DEFAULT;
      eff_reg   <= RATE_DEFAULT;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      size_reg  <= size_next;
      addr_reg  <= addr_next;
      rval_reg  <= rval_next;
      read_reg  <= read_next;
      pend_reg  <= pend_next;
      len_reg   <= len_next;
      idx_reg   <= idx_next;
      txd_reg   <= txd_next;
      cnt_reg   <= cnt_next;
      hop_reg   <= hop_next;
      pwr_reg   <= pwr_next;
      rate_reg  <= rate_next;
      eff_reg   <= eff_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs and hop lookup
  assign tx_data             = txd_reg;
  assign hop_sequence_select = hop_reg;
  assign tx_power_level      = pwr_reg;
  assign serial_rate_select  = eff_reg;
  assign baud_divisor        = rate_div(eff_reg);
  assign nv_busy             = (state_reg == ST_NVWAIT);

  rcfg_hop_rom u_hop_rom (
    .sys_clk   (sys_clk),
    .ce        (ce),
    .seq_sel   (hop_reg[2:0]),
    .hop_index (hop_index),
    .channel   (hop_channel)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n || !por_n);

  sequence write_taken_s;
    ce && cmd_done && !cmd_read && cmd_ok && cmd_addr < HOP_LIVE_ADDR;
  endsequence

  hop_range_a: assert property (hop_sequence_select <= HOP_MAX)
    else $error("hop select out of range");
  power_range_a: assert property (tx_power_level <= PWR_MAX)
    else $error("power code out of range");
  load_copy_a: assert property (ce && state_reg == ST_LOAD
                                |=> hop_reg == $past(hop_nv_reg) && eff_reg == $past(rate_nv_reg))
    else $error("live copies not loaded");
  // Rate in use moves only at the end of an acknowledge or at the reload after reset
  rate_switch_a: assert property (ce && $past(ce) && $changed(eff_reg)
                                 |-> ($past(last_tx) && $past(pend_reg)) || $past(state_reg) == ST_LOAD)
    else $error("rate changed outside acknowledge end");
  rate_after_ack_a: assert property (ce && last_tx && pend_reg |=> eff_reg == rate_reg)
    else $error("live rate not applied after reply");
  read_nack_a: assert property (ce && cmd_done && cmd_read && !cmd_ok |=> tx_valid && tx_data == NACK_BYTE)
    else $error("bad read not refused");
  write_ack_a: assert property (ce && cmd_done && !cmd_read && cmd_ok && cmd_addr >= HOP_LIVE_ADDR
                                |=> tx_valid && tx_data == ACK_BYTE)
    else $error("live write not acknowledged");
  nv_delay_a: assert property (write_taken_s ##1 ce [*8] |-> !tx_valid [*8])
    else $error("stored write answered early");
  reject_a: assert property (ce && cmd_done && !cmd_read && !cmd_ok
                             |=> $stable(hop_reg) && $stable(pwr_reg) && $stable(rate_reg)
                                 && $stable(hop_nv_reg) && $stable(pwr_nv_reg) && $stable(rate_nv_reg))
    else $error("rejected write changed a value");
endmodule
`default_nettype wire

// [rcfg_host.sv]
`timescale 1ns/100ps
`default_nettype none
module rcfg_host
  import rcfg_pkg::*;
(
  input  wire logic       sys_clk,  // System clock
  input  wire logic       stall,    // Take replies at random pace
  input  wire logic       rx_ready, // Command byte accepted
  output logic            rx_valid, // Command byte offered
  output logic      [7:0] rx_data,  // Command byte
  output logic            tx_ready, // Reply byte taken
  output logic            hung      // Handshake wait ran out
);
  import rcfg_pkg::*;

  // Idle line; tx_ready has its own process below
  initial
  begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    hung     = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Reply intake; ready every cycle, or at random while stall is high
  always @(negedge sys_clk)
    tx_ready <= stall ? 1'($urandom % 2) : 1'b1;

  // One byte, held until an edge sees it accepted
  task automatic send_byte(input logic [7:0] b);
    int n;
    @(negedge sys_clk);
    rx_valid = 1'b1;
    rx_data  = b;
    n = 0;
    while (rx_ready !== 1'b1 && n < 2000)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 2000)
      hung = 1'b1;
    @(posedge sys_clk);
  endtask

  // Released line shows the inverse of its last byte
  task automatic release_line();
    @(negedge sys_clk);
    rx_valid = 1'b0;
    rx_data  = ~rx_data;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Read: header, short size, escape, address
  task automatic rd(input logic [7:0] a);
    send_byte(HDR_BYTE);
    send_byte(SIZE_SHORT);
    send_byte(ESC_BYTE);
    send_byte(a);
    release_line();
  endtask

  // Write: header, short size, address, value
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    send_byte(HDR_BYTE);
    send_byte(SIZE_SHORT);
    send_byte(a);
    send_byte(v);
    release_line();
  endtask
endmodule
`default_nettype wire

// [radio_config_registers_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module radio_config_registers_tb;
  import rcfg_pkg::*;
  localparam int NVC = 20;
  logic        sys_clk, rst_n, por_n, stall, rx_valid, rx_ready, tx_valid, tx_ready, hung, nv_busy, ce;
  logic [7:0]  rx_data, tx_data, hop_sel, power_code, rate, pc, old;
  logic [4:0]  hop_index, chan;
  logic [15:0] div;
  logic [7:0]  exp_q [$];
  int          fails, check_count, n;
  int          baud     [8] = '{BAUD_0, BAUD_1, BAUD_2, BAUD_3, BAUD_4, BAUD_5, BAUD_6, BAUD_7};
  int          first_ch [6] = '{16, 15, 3, 28, 22, 9};
  int          last_ch  [6] = '{26, 5, 13, 18, 0, 31};

  rcfg_regs #(.NV_CYCLES(NVC)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .por_n(por_n), .ce(ce),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .hop_index(hop_index), .hop_channel(chan), .hop_sequence_select(hop_sel),
    .tx_power_level(power_code), .serial_rate_select(rate), .baud_divisor(div), .nv_busy(nv_busy));
  rcfg_host host (.sys_clk(sys_clk), .stall(stall), .rx_ready(rx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_ready(tx_ready), .hung(hung));

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Compare a port value
  task automatic chk_port(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t port got %h want %h", $time, got, exp);
    end
  endtask

  // Compare a reply byte
  task automatic chk_reply(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t reply got %h want %h", $time, got, exp);
    end
  endtask

  // Each reply byte taken is matched to the oldest note
  always @(posedge sys_clk)
  begin
    if (hung === 1'b1)
    begin
      fails++;
      conclude();
    end
    else if (tx_valid === 1'b1 && tx_ready === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        fails++;
        $display("[FAIL] %0t unexpected reply %h", $time, tx_data);
      end
      else
        chk_reply(tx_data, exp_q.pop_front());
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command helpers noting the expected replies
  task automatic rd(input logic [7:0] a, input logic [7:0] v, input logic ok);
    if (ok)
      exp_q.push_back(ACK_BYTE);
    else
      exp_q.push_back(NACK_BYTE);
    if (ok)
      exp_q.push_back(a);
    if (ok)
      exp_q.push_back(v);
    host.rd(a);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic ok);
    exp_q.push_back(ok ? ACK_BYTE : NACK_BYTE);
    host.wr(a, v);
  endtask

  task automatic drain();
    n = 0;
    while (exp_q.size() != 0 && n < 3000)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 3000)
    begin
      fails++;
      conclude();
    end
    else
      @(negedge sys_clk);
  endtask

  task automatic do_reset(input logic por);
    @(negedge sys_clk);
    rst_n = 1'b0;
    por_n = ~por;
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    por_n = 1'b1;
    repeat (2) @(negedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    por_n = 1'b0;
    ce = 1'b1;
    stall = 1'b0;
    hop_index = 5'd0;
    fails = 0;
    check_count = 0;
    void'($urandom(32'hb58c));
    do_reset(1'b1);
    chk_port(16'(hop_sel), 16'(HOP_DEFAULT));
    chk_port(16'(power_code), 16'h0003);
    chk_port(16'(div), 16'(CLK_HZ / BAUD_1));
    rd(HOP_LIVE_ADDR, 8'h00, 1'b1);
    rd(PWR_LIVE_ADDR, 8'h03, 1'b1);
    rd(RATE_LIVE_ADDR, RATE_DEFAULT, 1'b1);
    rd(HOP_NV_ADDR, 8'h00, 1'b1);
    rd(PWR_NV_ADDR, 8'h03, 1'b1);
    rd(RATE_NV_ADDR, RATE_DEFAULT, 1'b1);
    rd(8'h40, 8'h00, 1'b0);
    wr(8'h01, 8'h00, 1'b0);
    drain();
    for (int c = 0; c <= 4; c++)
    begin
      wr(PWR_LIVE_ADDR, 8'(c), c <= 3);
      drain();
      chk_port(16'(power_code), c <= 3 ? 16'(c) : 16'h0003);
    end
    stall = 1'b1;
    for (int s = 0; s <= 6; s++)
    begin
      wr(HOP_LIVE_ADDR, 8'(s), s <= 5);
      drain();
      chk_port(16'(hop_sel), s <= 5 ? 16'(s) : 16'h0005);
      if (s <= 5)
      begin
        hop_index = 5'd0;
        @(negedge sys_clk);
        chk_port(16'(chan), 16'(first_ch[s]));
        hop_index = 5'd25;
        @(negedge sys_clk);
        chk_port(16'(chan), 16'(last_ch[s]));
      end
    end
    // Clock enable low freezes the channel register
    ce = 1'b0;
    hop_index = 5'd0;
    repeat (3) @(negedge sys_clk);
    chk_port(16'(chan), 16'(last_ch[5]));
    ce = 1'b1;
    @(negedge sys_clk);
    chk_port(16'(chan), 16'(first_ch[5]));
    hop_index = 5'($urandom % 26);
    for (int r = 0; r <= 8; r++)
    begin
      old = rate;
      wr(RATE_LIVE_ADDR, 8'(r), r <= 7);
      chk_port(16'(tx_valid), 16'h0001);
      chk_port(16'(rate), 16'(old));
      drain();
      chk_port(16'(rate), r <= 7 ? 16'(r) : 16'h0007);
      chk_port(div, 16'(CLK_HZ / baud[r <= 7 ? r : 7]));
    end
    stall = 1'b0;
    wr(RATE_LIVE_ADDR, 8'h01, 1'b1);
    drain();
    pc = 8'($urandom % 4);
    wr(PWR_NV_ADDR, pc, 1'b1);
    chk_port(16'(nv_busy), 16'h0001);
    n = 1;
    while (tx_valid !== 1'b1 && n < 200)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk_port(16'(n), 16'(NVC + 1));
    drain();
    chk_port(16'(power_code), 16'h0003);
    wr(RATE_NV_ADDR, 8'h05, 1'b1);
    wr(HOP_NV_ADDR, 8'h04, 1'b1);
    wr(HOP_NV_ADDR, 8'h06, 1'b0);
    rd(RATE_NV_ADDR, 8'h05, 1'b1);
    drain();
    chk_port(16'(rate), 16'h0001);
    do_reset(1'b0);
    chk_port(16'(rate), 16'h0005);
    chk_port(div, 16'(CLK_HZ / BAUD_5));
    chk_port(16'(power_code), 16'(pc));
    chk_port(16'(hop_sel), 16'h0004);
    host.send_byte(8'h12);
    host.send_byte(HDR_BYTE);
    host.send_byte(8'h05);
    exp_q.push_back(NACK_BYTE);
    host.send_byte(HDR_BYTE);
    host.send_byte(SIZE_LONG);
    host.send_byte(PWR_LIVE_ADDR);
    host.send_byte(ESC_BYTE);
    host.send_byte(8'h01);
    host.release_line();
    drain();
    rd(PWR_LIVE_ADDR, pc, 1'b1);
    drain();
    do_reset(1'b1);
    chk_port(16'(rate), 16'(RATE_DEFAULT));
    chk_port(16'(hop_sel), 16'(HOP_DEFAULT));
    conclude();
  end
endmodule
`default_nettype wire
